// ---- rtl/rcss_top.v ----
/*
 Reset sequencer and reset-cause recorder. Holds the internal reset through
 the start-up delays, records the cause of each reset or Sleep wake, and chooses
 where execution resumes.
 Assumes event inputs are synchronous single-cycle pulses on clk, and that
 reset_n is the power-on event itself (its release starts the power-up path).
*/
`timescale 1ns/10ps
`include "rcss_defs.vh"

module rcss_top (
	input  wire                       clk,
	input  wire                       reset_n,
	input  wire                       brown_out,
	input  wire                       master_clear_pin,
	input  wire                       soft_reset_req,
	input  wire                       watchdog_timeout,
	input  wire                       irq_wake,
	input  wire                       irq_enabled,
	input  wire [`RCSS_PC_W-1:0]      irq_vector,
	input  wire                       clock_fail,
	input  wire                       trap_conflict,
	input  wire                       illegal_op,
	input  wire                       sleep_req,
	input  wire                       idle_req,
	input  wire [`RCSS_PC_W-1:0]      pc_now,
	input  wire                       osc_stable,
	input  wire                       cfg_crystal,
	input  wire                       cfg_supply_settle_timer_zero,
	input  wire                       cfg_watchdog_on,
	input  wire [`RCSS_CLKSRC_W-1:0]  cfg_clksrc,
	input  wire [`RCSS_ADDR_W-1:0]    reg_addr,
	input  wire [15:0]                reg_wdata,
	input  wire                       reg_wr,
	input  wire                       reg_rd,
	output reg  [15:0]                reg_rdata,
	output reg                        core_reset,
	output reg                        core_halt,
	output reg                        clocks_run,
	output reg                        pc_load,
	output reg  [`RCSS_PC_W-1:0]      pc_target,
	output reg                        watchdog_enable,
	output reg  [`RCSS_CLKSRC_W-1:0]  clk_source
);

// ==========================================================
// Sequencer states
localparam ST_POR   = 3'h0;
localparam ST_SUPPLY_SETTLE_TIMER  = 3'h1;
localparam ST_OST   = 3'h2;
localparam ST_RUN   = 3'h3;
localparam ST_SLEEP = 3'h4;
localparam ST_IDLE  = 3'h5;
localparam ST_HOLD  = 3'h6;

// Cycle counts worked out as integers, then cut to the counter width
localparam integer POR_INT  = `RCSS_US2CYC(`RCSS_POR_US);
localparam integer SUPPLY_SETTLE_TIMER_INT = `RCSS_US2CYC(`RCSS_SUPPLY_SETTLE_TIMER_US);
localparam integer CLOCK_FAIL_MONITOR_INT = `RCSS_US2CYC(`RCSS_CLOCK_FAIL_MONITOR_US);
localparam [`RCSS_CNT_W-1:0] POR_CYC  = POR_INT[`RCSS_CNT_W-1:0];
localparam [`RCSS_CNT_W-1:0] SUPPLY_SETTLE_TIMER_CYC = SUPPLY_SETTLE_TIMER_INT[`RCSS_CNT_W-1:0];
localparam [`RCSS_CNT_W-1:0] CLOCK_FAIL_MONITOR_CYC = CLOCK_FAIL_MONITOR_INT[`RCSS_CNT_W-1:0];

reg  [2:0]                state;
reg  [2:0]                next_state;
reg                       power_up;
reg                       sw_wd_enable;
reg                       dly_start;
reg  [`RCSS_CNT_W-1:0]    dly_count;
wire                      dly_done;
wire [`RCSS_CAUSE_W-1:0]  cause;
reg                       ev_cap;
reg  [`RCSS_CAUSE_W-1:0]  ev_set;
reg  [`RCSS_CAUSE_W-1:0]  ev_clr;
reg                       ev_reset;
reg                       ev_jump;
reg  [`RCSS_PC_W-1:0]     ev_pc;
wire                      sw_cause_wr;
wire [`RCSS_CAUSE_W-1:0]  all_mode_bits;

assign sw_cause_wr   = reg_wr && (reg_addr == `RCSS_OFS_CAUSE);
assign all_mode_bits = {`RCSS_CAUSE_W{1'b1}};

// ==========================================================
// Start-up delay counter
rcss_delay u_delay (
	.clk     (clk),
	.reset_n (reset_n),
	.start   (dly_start),
	.count   (dly_count),
	.done    (dly_done)
);

// ==========================================================
// Cause register
rcss_regbank u_regs (
	.clk     (clk),
	.reset_n (reset_n),
	.sw_wr   (sw_cause_wr),
	.sw_data (reg_wdata[`RCSS_CAUSE_W-1:0]),
	.hw_cap  (ev_cap),
	.hw_set  (ev_set),
	.hw_clr  (ev_clr),
	.cause   (cause)
);

// ==========================================================
// Event decode; resets outrank interrupt wake, watchdog wake outranks trap, illegal-op and soft resets, clock fail is lowest
always @* begin
	ev_cap   = 1'b0;
	ev_set   = `RCSS_CAUSE_ZERO;
	ev_clr   = `RCSS_CAUSE_ZERO;
	ev_reset = 1'b0;
	ev_jump  = 1'b0;
	ev_pc    = `RCSS_PC_RESET;
	if (state == ST_POR || state == ST_SUPPLY_SETTLE_TIMER || state == ST_OST) begin
		ev_cap = 1'b0;
	end else if (brown_out) begin
		// Detector stays live in every power mode
		ev_cap   = 1'b1; // R3
		ev_reset = 1'b1;
		ev_set[`RCSS_BIT_BOR] = 1'b1; // R2
		ev_clr[`RCSS_BIT_POR] = 1'b1;
	end else if (master_clear_pin) begin
		ev_cap   = 1'b1;
		ev_reset = 1'b1; // R12
		ev_set[`RCSS_BIT_PIN] = 1'b1;
		ev_clr[`RCSS_BIT_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		if (state == ST_SLEEP) begin
			ev_set[`RCSS_BIT_SLEEP] = 1'b1; // R10
			ev_clr[`RCSS_BIT_IDLE]  = 1'b1;
		end else if (state == ST_IDLE) begin
			ev_set[`RCSS_BIT_IDLE]  = 1'b1; // R11
			ev_clr[`RCSS_BIT_SLEEP] = 1'b1;
		end else begin
			ev_clr[`RCSS_BIT_SOFT]  = 1'b1; // R8
			ev_clr[`RCSS_BIT_SLEEP] = 1'b1;
			ev_clr[`RCSS_BIT_IDLE]  = 1'b1;
		end
	end else if (watchdog_timeout && state == ST_SLEEP) begin
		ev_cap  = 1'b1;
		ev_jump = 1'b1; // R12
		ev_pc   = pc_now + `RCSS_PC_STEP; // R13
		ev_set[`RCSS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
		ev_set[`RCSS_BIT_SLEEP] = 1'b1;
	end else if (watchdog_timeout) begin
		ev_cap   = 1'b1;
		ev_reset = 1'b1; // R13
		ev_set[`RCSS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
		ev_clr[`RCSS_BIT_PIN]   = 1'b1;
		ev_clr[`RCSS_BIT_SOFT]  = 1'b1;
		ev_clr[`RCSS_BIT_SLEEP] = 1'b1;
		ev_clr[`RCSS_BIT_IDLE]  = 1'b1;
	end else if (trap_conflict) begin
		ev_cap   = 1'b1;
		ev_reset = 1'b1;
		ev_set[`RCSS_BIT_TRAP] = 1'b1; // R16
	end else if (illegal_op) begin
		ev_cap   = 1'b1;
		ev_reset = 1'b1;
		ev_set[`RCSS_BIT_ILLOP] = 1'b1; // R16
	end else if (soft_reset_req && state == ST_RUN) begin
		ev_cap   = 1'b1;
		ev_reset = 1'b1;
		ev_set[`RCSS_BIT_SOFT]  = 1'b1; // R9
		ev_clr[`RCSS_BIT_PIN]   = 1'b1;
		ev_clr[`RCSS_BIT_WATCHDOG_TIMEOUT_FLAG]  = 1'b1;
		ev_clr[`RCSS_BIT_SLEEP] = 1'b1;
		ev_clr[`RCSS_BIT_IDLE]  = 1'b1;
	end else if (irq_wake && (state == ST_SLEEP || state == ST_IDLE)) begin
		// Only Sleep is flagged; WDT bit left untouched
		ev_cap  = (state == ST_SLEEP);
		ev_jump = 1'b1;
		ev_set[`RCSS_BIT_SLEEP] = (state == ST_SLEEP); // R14
		ev_pc   = irq_enabled ? irq_vector : pc_now + `RCSS_PC_STEP; // R21
	end else if (clock_fail && state == ST_RUN) begin
		ev_jump = 1'b1;
		ev_pc   = `RCSS_PC_CLKFAIL; // R15
	end
end

// ==========================================================
// Sequencer
always @* begin
	next_state = state;
	dly_start  = 1'b0;
	dly_count  = POR_CYC;
	case (state)
		ST_POR: begin
			if (dly_done) begin
				next_state = ST_SUPPLY_SETTLE_TIMER;
				dly_start  = 1'b1;
				// Settle time only after a true power-up
				if (!power_up)
					dly_count = {`RCSS_CNT_W{1'b0}}; // R7
				else if (cfg_supply_settle_timer_zero && cfg_crystal)
					dly_count = CLOCK_FAIL_MONITOR_CYC; // R5
				else if (cfg_supply_settle_timer_zero)
					dly_count = {`RCSS_CNT_W{1'b0}};
				else
					dly_count = SUPPLY_SETTLE_TIMER_CYC;
			end
		end
		ST_SUPPLY_SETTLE_TIMER: begin
			if (dly_done)
				next_state = ST_OST; // R4
		end
		ST_OST: begin
			if (osc_stable || !cfg_crystal)
				next_state = ST_RUN; // R6
		end
		ST_RUN: begin
			if (ev_reset)
				next_state = ST_HOLD;
			else if (sleep_req)
				next_state = ST_SLEEP;
			else if (idle_req)
				next_state = ST_IDLE;
		end
		ST_SLEEP, ST_IDLE: begin
			if (ev_reset)
				next_state = ST_HOLD;
			else if (ev_jump)
				next_state = ST_RUN;
		end
		ST_HOLD: begin
			next_state = ST_POR;
			dly_start  = 1'b1;
		end
		default: begin
			next_state = ST_POR;
		end
	endcase
end

always @(posedge clk) begin
	if (!reset_n) begin
		state    <= ST_HOLD;
		power_up <= 1'b1;
	end else begin
		state <= next_state;
		if (state == ST_SUPPLY_SETTLE_TIMER)
			power_up <= 1'b0;
		else if (ev_reset && brown_out)
			power_up <= 1'b0;
	end
end

// ==========================================================
// Outputs, all registered
always @(posedge clk) begin
	if (!reset_n) begin
		core_reset      <= 1'b1;
		core_halt       <= 1'b0;
		clocks_run      <= 1'b1;
		pc_load         <= 1'b0;
		pc_target       <= `RCSS_PC_RESET;
		clk_source      <= {`RCSS_CLKSRC_W{1'b0}};
		sw_wd_enable    <= 1'b0;
		watchdog_enable <= 1'b0;
		reg_rdata       <= 16'h0000;
	end else begin
		// R4 R6
		core_reset <= (next_state == ST_POR) || (next_state == ST_SUPPLY_SETTLE_TIMER) ||
			(next_state == ST_OST) || (next_state == ST_HOLD);
		core_halt  <= (next_state == ST_SLEEP) || (next_state == ST_IDLE);
		clocks_run <= (next_state != ST_SLEEP); // R18
		pc_load    <= ev_reset || ev_jump;
		if (ev_reset)
			pc_target <= `RCSS_PC_RESET; // R1
		else if (ev_jump)
			pc_target <= ev_pc;
		// Brown-out pulse is gone by HOLD, so capture at the event
		if ((state == ST_HOLD && power_up) || (ev_reset && brown_out))
			clk_source <= cfg_clksrc; // R19
		else if (reg_wr && reg_addr == `RCSS_OFS_CLKSEL)
			clk_source <= reg_wdata[`RCSS_CLKSRC_W-1:0];
		if (reg_wr && reg_addr == `RCSS_OFS_CTRL)
			sw_wd_enable <= reg_wdata[0];
		watchdog_enable <= cfg_watchdog_on || sw_wd_enable; // R20
		reg_rdata <= 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`RCSS_OFS_CAUSE:  reg_rdata <= {6'h00, cause}; // R17
				`RCSS_OFS_CTRL:   reg_rdata <= {15'h0000, sw_wd_enable};
				`RCSS_OFS_STATUS: reg_rdata <= {12'h000, power_up, state};
				`RCSS_OFS_CLKSEL: reg_rdata <= {13'h0000, clk_source};
				default:          reg_rdata <= 16'h0000;
			endcase
		end
	end
end

// Reset values of the cause register already hold the power-on pattern R1
// and any bit not in a set or clear mask holds its value R22

endmodule

// ---- rtl/rcss_defs.vh ----
/*
 Constants for the reset-cause and start-up sequencer: register offsets,
 flag positions, restart addresses and start-up delays.
 Assumes a 20 MHz system clock and a 24-bit program counter.
*/
// Overview of operation
// R1: Power-on restarts at zero, sets power-on and brown-out flags, clears all others.
// R2: Brown-out reset sets brown-out flag, bit 1, restarts at zero.
// R3: Enabled brown-out detection keeps working and resets in Sleep and Idle.
// R4: Internal reset held until power-on delay and settle delay both elapse.
// R5: Zero settle delay with crystal uses about 100 us clock-monitor delay.
// R6: Oscillator start-up timer holds reset until crystal is stable.
// R7: Supply-settle delay applies only on power-up, not other resets.
// R8: Pin reset while running sets only the pin-reset flag, restarts at zero.
// R9: Software reset while running sets only the soft-reset flag, restarts at zero.
// R10: Pin reset in Sleep sets pin-reset and Sleep flags, restarts at zero.
// R11: Pin reset in Idle sets pin-reset and Idle flags, restarts at zero.
// R12: Sleep ends on pin reset, watchdog wake or interrupt.
// R13: Watchdog reset when running; in Sleep wakes to PC+2 with watchdog, Sleep flags.
// R14: Interrupt wake sets Sleep flag only, continues at PC+2 or vector.
// R15: Clock failure trap jumps to 0x000004 touching no cause flags.
// R16: Trap reset sets trap flag, illegal op sets illegal flag, restart zero.
// R17: Cause flags are software read/write; software clears them before events.
// R18: Idle keeps clocks running while the core is halted.
// R19: Power-on and brown-out take clock source from configuration bits.
// R20: Watchdog runs on its own RC oscillator, forced on or software controlled.
// R21: Enabled-interrupt wake loads that interrupt's vector address.
// R22: Flags an event does not name keep their previous value.
// R23: Cause flags captured in the same cycle the reset or wake asserts.
`ifndef RCSS_DEFS_VH
`define RCSS_DEFS_VH

// ==========================================================
// Register map
`define RCSS_ADDR_W       4
`define RCSS_OFS_CAUSE    4'h0
`define RCSS_OFS_CTRL     4'h1
`define RCSS_OFS_STATUS   4'h2
`define RCSS_OFS_CLKSEL   4'h3

// ==========================================================
// Cause flag positions
`define RCSS_CAUSE_W      10
`define RCSS_BIT_BOR      1
`define RCSS_BIT_POR      0
`define RCSS_BIT_SLEEP    2
`define RCSS_BIT_IDLE     3
`define RCSS_BIT_WATCHDOG_TIMEOUT_FLAG     4
`define RCSS_BIT_SOFT     5
`define RCSS_BIT_PIN      6
`define RCSS_BIT_ILLOP    8
`define RCSS_BIT_TRAP     9
`define RCSS_CAUSE_POR    10'h003
`define RCSS_CAUSE_ZERO   10'h000

// ==========================================================
// Restart addresses
`define RCSS_PC_W         24
`define RCSS_PC_RESET     24'h000000
`define RCSS_PC_CLKFAIL   24'h000004
`define RCSS_PC_STEP      24'h000002

// ==========================================================
// Power modes
`define RCSS_MODE_RUN     2'h0
`define RCSS_MODE_SLEEP   2'h1
`define RCSS_MODE_IDLE    2'h2

// ==========================================================
// Start-up timing at 20 MHz
`define RCSS_CLK_MHZ      20
`define RCSS_CNT_W        20
`define RCSS_POR_US       10
`define RCSS_SUPPLY_SETTLE_TIMER_US      64
`define RCSS_CLOCK_FAIL_MONITOR_US      100
`define RCSS_US2CYC(u)    ((u) * `RCSS_CLK_MHZ)
`define RCSS_CLKSRC_W     3

`endif

// ---- rtl/rcss_delay.v ----
/*
 One-shot delay counter: a start pulse loads a count, done rises when it
 reaches zero. Assumes start is a single-cycle pulse on clk.
*/
`timescale 1ns/10ps
`include "rcss_defs.vh"

module rcss_delay (
	input  wire                   clk,
	input  wire                   reset_n,
	input  wire                   start,
	input  wire [`RCSS_CNT_W-1:0] count,
	output reg                    done
);

reg [`RCSS_CNT_W-1:0] remain;

always @(posedge clk) begin
	if (!reset_n) begin
		remain <= {`RCSS_CNT_W{1'b0}};
		done   <= 1'b0;
	end else if (start) begin
		remain <= count;
		done   <= (count == {`RCSS_CNT_W{1'b0}});
	end else if (remain != {`RCSS_CNT_W{1'b0}}) begin
		remain <= remain - {{(`RCSS_CNT_W-1){1'b0}}, 1'b1};
		done   <= (remain == {{(`RCSS_CNT_W-1){1'b0}}, 1'b1});
	end
end

endmodule

// ---- rtl/rcss_regbank.v ----
/*
 Software-visible cause register with hardware capture. Hardware set and
 clear masks win over a software write in the same cycle.
 Assumes the capture strobes are single-cycle pulses.
*/
`timescale 1ns/10ps
`include "rcss_defs.vh"

module rcss_regbank (
	input  wire                     clk,
	input  wire                     reset_n,
	input  wire                     sw_wr,
	input  wire [`RCSS_CAUSE_W-1:0] sw_data,
	input  wire                     hw_cap,
	input  wire [`RCSS_CAUSE_W-1:0] hw_set,
	input  wire [`RCSS_CAUSE_W-1:0] hw_clr,
	output reg  [`RCSS_CAUSE_W-1:0] cause
);

// ==========================================================
// Per-bit flag with set over clear over write
localparam [`RCSS_CAUSE_W-1:0] POR_PAT = `RCSS_CAUSE_POR;

genvar i;
generate
	for (i = 0; i < `RCSS_CAUSE_W; i = i + 1) begin : g_flag
		always @(posedge clk) begin
			if (!reset_n)
				cause[i] <= POR_PAT[i];
			else if (hw_cap && hw_set[i])
				cause[i] <= 1'b1; // R23
			else if (hw_cap && hw_clr[i])
				cause[i] <= 1'b0;
			else if (sw_wr)
				cause[i] <= sw_data[i]; // R17
		end
	end
endgenerate

endmodule

// ---- testbench/rcss_far_model.sv ----
/*
 Far-side model: master-clear pin, supply monitor and crystal oscillator.
 Assumes the bench requests pin and supply events one cycle ahead.
*/
`timescale 1ns/10ps

module rcss_far_model #(
	parameter int OSC_CYC = 300
) (
	input  wire logic clk,
	input  wire logic clocks_run,
	input  wire logic pin_cmd,
	input  wire logic bor_cmd,
	output logic      osc_stable,
	output logic      master_clear_pin,
	output logic      brown_out
);
	// ==========================================
	// Crystal restarts after Sleep or a supply dip
	int cnt = 0;

	initial begin
		osc_stable = 1'h0;
		master_clear_pin = 1'h0;
		brown_out = 1'h0;
	end

	always @(posedge clk) begin
		master_clear_pin <= pin_cmd;
		brown_out <= bor_cmd;
		if (!clocks_run || bor_cmd)
			cnt <= 0;
		else if (cnt < OSC_CYC)
			cnt <= cnt + 1;
		osc_stable <= clocks_run && cnt >= OSC_CYC;
	end
endmodule

// ---- testbench/rcss_top_sva.sv ----
/*
 Checker for the sequencer top: restart targets, hold times, mode entry.
 Assumes single-cycle event pulses and a 20 MHz clock.
*/
`timescale 1ns/10ps
`include "rcss_defs.vh"

module rcss_top_sva (
	input wire logic                  clk,
	input wire logic                  reset_n,
	input wire logic                  brown_out,
	input wire logic                  master_clear_pin,
	input wire logic                  soft_reset_req,
	input wire logic                  watchdog_timeout,
	input wire logic                  irq_wake,
	input wire logic                  irq_enabled,
	input wire logic [`RCSS_PC_W-1:0] irq_vector,
	input wire logic                  clock_fail,
	input wire logic                  trap_conflict,
	input wire logic                  illegal_op,
	input wire logic                  sleep_req,
	input wire logic                  idle_req,
	input wire logic [`RCSS_PC_W-1:0] pc_now,
	input wire logic                  osc_stable,
	input wire logic                  cfg_crystal,
	input wire logic                  cfg_watchdog_on,
	input wire logic                  core_reset,
	input wire logic                  core_halt,
	input wire logic                  clocks_run,
	input wire logic                  pc_load,
	input wire logic [`RCSS_PC_W-1:0] pc_target,
	input wire logic                  watchdog_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ==========================================
	// Helper logic
	logic [15:0] high_cnt;
	wire logic above_irq = brown_out | master_clear_pin | watchdog_timeout | trap_conflict
		| illegal_op | soft_reset_req;
	wire logic any_ev = above_irq | irq_wake | clock_fail;

	always @(posedge clk) begin
		if (!reset_n || !core_reset)
			high_cnt <= 16'h0;
		else if (high_cnt != 16'hffff)
			high_cnt <= high_cnt + 16'h1;
	end

	// ==========================================
	// Assertions
	pin_restart_a: assert property (master_clear_pin && !brown_out && !core_reset
		|=> pc_load && core_reset && pc_target == 24'h0) else $error("pin reset restart wrong");
	trap_restart_a: assert property ((trap_conflict || illegal_op) && !core_reset
		&& !(brown_out || master_clear_pin || watchdog_timeout)
		|=> core_reset && pc_target == 24'h0) else $error("trap restart wrong");
	wdt_wake_a: assert property (watchdog_timeout && !clocks_run && !core_reset
		&& !brown_out && !master_clear_pin
		|=> pc_load && !core_reset && pc_target == $past(pc_now) + 24'h2)
		else $error("watchdog wake target wrong");
	irq_vector_a: assert property (irq_wake && irq_enabled && !clocks_run && !above_irq
		&& !core_reset |=> pc_load && pc_target == $past(irq_vector))
		else $error("interrupt vector not loaded");
	clk_fail_a: assert property (clock_fail && !above_irq && !irq_wake && !core_halt
		&& !core_reset |=> pc_load && !core_reset && pc_target == 24'h4)
		else $error("clock failure target wrong");
	idle_enter_a: assert property (idle_req && !sleep_req && !any_ev && !core_halt
		&& !core_reset |=> core_halt && clocks_run) else $error("idle entry wrong");
	sleep_enter_a: assert property (sleep_req && !any_ev && !core_halt && !core_reset
		|=> core_halt && !clocks_run) else $error("sleep entry wrong");
	por_hold_a: assert property ($fell(core_reset) |-> high_cnt >= 16'd200)
		else $error("internal reset released early");
	osc_wait_a: assert property ($fell(core_reset) && cfg_crystal |-> $past(osc_stable))
		else $error("reset released before crystal stable");
	wdog_cfg_a: assert property (cfg_watchdog_on |=> watchdog_enable)
		else $error("forced watchdog not enabled");
endmodule

bind rcss_top rcss_top_sva u_sva (.*);

// ---- testbench/rcss_top_tb.sv ----
/*
 Self-checking bench for the reset-cause and start-up sequencer.
 Assumes the far-side model drives pin, supply and crystal lines.
*/
`timescale 1ns/10ps
`include "rcss_defs.vh"

`define CHK(nm, ex, gt) \
	begin \
		total_checks++; \
		if ((gt) !== (ex)) begin \
			n_mismatch++; \
			$display("unexpected %s expected %h seen %h", nm, ex, gt); \
		end \
	end

module rcss_top_tb;
	// ==========================================
	// Signals
	logic        clk = 1'h0, reset_n = 1'h0, pin_cmd = 1'h0, bor_cmd = 1'h0;
	logic        soft_reset_req = 1'h0, watchdog_timeout = 1'h0, irq_wake = 1'h0;
	logic        irq_enabled = 1'h0, clock_fail = 1'h0, trap_conflict = 1'h0;
	logic        illegal_op = 1'h0, sleep_req = 1'h0, idle_req = 1'h0, cfg_crystal = 1'h1;
	logic        cfg_supply_settle_timer_zero = 1'h0, cfg_watchdog_on = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [23:0] irq_vector = 24'h0, pc_now = 24'h0;
	logic [2:0]  cfg_clksrc = 3'h5;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0, d;
	wire         osc_stable, master_clear_pin, brown_out, core_reset, core_halt;
	wire         clocks_run, pc_load, watchdog_enable;
	wire [15:0]  reg_rdata;
	wire [23:0]  pc_target;
	wire [2:0]   clk_source;
	logic [31:0] lf = 32'h2a67;
	logic [9:0]  pre;
	int          n_mismatch = 0, total_checks = 0, k, n;

	rcss_top u_dut (.*);
	rcss_far_model #(.OSC_CYC(300)) u_far (.*);

	always #25 clk = ~clk;

	// ==========================================
	// Expectation functions
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Packed as {set mask, clear mask}
	function automatic logic [9:0] exp_cause(input int k, input logic [9:0] p);
		logic [19:0] m;
		case (k)
			0: m = 20'h1003c;
			1: m = 20'h0805c;
			2: m = 20'h11018;
			3: m = 20'h12014;
			4: m = 20'h0406c;
			5: m = 20'h05000;
			6, 7: m = 20'h01000;
			9: m = 20'h80000;
			10: m = 20'h40000;
			11, 12: m = 20'h00801;
			default: m = 20'h00000;
		endcase
		return (p & ~m[9:0]) | m[19:10];
	endfunction

	function automatic logic [23:0] exp_pc(input int k);
		case (k)
			5, 6: return pc_now + 24'h2;
			7: return irq_vector;
			8: return 24'h4;
			default: return 24'h0;
		endcase
	endfunction

	// ==========================================
	// Bus and sequencing tasks
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		v = reg_rdata;
	endtask

	task automatic wait_run(output int c);
		c = 0;
		while (core_reset !== 1'h0 && c < 5000) begin
			@(posedge clk);
			#1;
			c++;
		end
		if (c >= 5000) begin
			n_mismatch++;
			wrap_up();
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask

	// Pin and supply events go through the far-side model
	task automatic fire(input int k);
		@(posedge clk);
		case (k)
			0, 2, 3: pin_cmd <= 1'h1;
			1: soft_reset_req <= 1'h1;
			4, 5: watchdog_timeout <= 1'h1;
			6, 7: irq_wake <= 1'h1;
			8: clock_fail <= 1'h1;
			9: trap_conflict <= 1'h1;
			10: illegal_op <= 1'h1;
			default: bor_cmd <= 1'h1;
		endcase
		irq_enabled <= (k == 7);
		@(posedge clk);
		{pin_cmd, soft_reset_req, watchdog_timeout, irq_wake} <= 4'h0;
		{clock_fail, trap_conflict, illegal_op, bor_cmd} <= 4'h0;
	endtask

	// ==========================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		rd(4'h0, d);
		`CHK("cause", 16'h0003, d)
		wait_run(n);
		`CHK("settle_cycles", 1'h1, n > 1400 && n < 1700)
		`CHK("clk_source", 3'h5, clk_source)
		for (k = 0; k < 13; k++) begin
			lf = lfsr(lf);
			// Bit 7 has no flag behind it, so it is always written as zero
			pre = lf[9:0] & 10'h37f;
			wr(4'h0, {6'h0, pre});
			pc_now <= lf[31:8];
			irq_vector <= lf[27:4] | 24'h100;
			if (k == 2 || k == 3 || k == 5 || k == 6 || k == 7 || k == 12) begin
				@(posedge clk);
				if (k == 3)
					idle_req <= 1'h1;
				else
					sleep_req <= 1'h1;
				@(posedge clk);
				{sleep_req, idle_req} <= 2'h0;
				settle();
				`CHK("core_halt", 1'h1, core_halt)
				`CHK("clocks_run", k == 3, clocks_run)
			end
			if (k == 11)
				wr(4'h3, 16'h0001);
			fire(k);
			n = 0;
			#1;
			while (pc_load !== 1'h1 && n < 4) begin
				@(posedge clk);
				#1;
				n++;
			end
			`CHK("pc_target", exp_pc(k), pc_target)
			`CHK("core_reset", exp_pc(k) == 24'h0, core_reset)
			wait_run(n);
			if (exp_pc(k) == 24'h0)
				`CHK("restart_short", 1'h1, n < 1280)
			`CHK("core_halt", 1'h0, core_halt)
			rd(4'h0, d);
			`CHK("cause", {6'h0, exp_cause(k, pre)}, d)
			if (k == 11)
				`CHK("clk_source", 3'h5, clk_source)
		end
		lf = lfsr(lf);
		wr(4'h0, {6'h0, lf[9:0] & 10'h37f});
		cfg_clksrc <= 3'h2;
		cfg_supply_settle_timer_zero <= 1'h1;
		reset_n <= 1'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'h1;
		wait_run(n);
		`CHK("zero_settle_cycles", 1'h1, n > 2150 && n < 2400)
		`CHK("clk_source", 3'h2, clk_source)
		rd(4'h0, d);
		`CHK("cause", 16'h0003, d)
		wr(4'h0, 16'h0155);
		wr(4'hc, 16'hffff);
		rd(4'hc, d);
		`CHK("unmapped", 16'h0000, d)
		rd(4'h0, d);
		`CHK("cause", 16'h0155, d)
		wr(4'h1, 16'h0001);
		settle();
		`CHK("watchdog_enable", 1'h1, watchdog_enable)
		wr(4'h1, 16'h0000);
		settle();
		`CHK("watchdog_enable", 1'h0, watchdog_enable)
		cfg_watchdog_on <= 1'h1;
		settle();
		`CHK("watchdog_enable", 1'h1, watchdog_enable)
		wrap_up();
	end
endmodule
